/* logic/smm_defs.svh */
`ifndef SMM_DEFS_SVH
`define SMM_DEFS_SVH
// sample widths
`define SMM_SPD_W 24
`define SMM_POS_W 32
// monitoring cycle: 62.5 us at 10 MHz, cycle count derived from the time in ns
`define SMM_CYCLE_NS 62500
`define SMM_CLK_NS 100
`define SMM_CYCLE_CLKS (`SMM_CYCLE_NS / `SMM_CLK_NS)
`define SMM_DIV_W 10
// error reaction encodings
`define SMM_REACT_TORQUE_OFF 2'h0
`define SMM_REACT_STOP1_FIRST 2'h1
`define SMM_REACT_STOP1_SECOND 2'h2
// allowed direction
`define SMM_DIR_POS 1'b0
`define SMM_DIR_NEG 1'b1
// snapshot memory address width (sample, monitor): 2 bits, 4 entries
`define SMM_HIST_AW 2
`endif

/* logic/smm_pkg.sv */
package smm_pkg;
  `include "smm_defs.svh"
  typedef logic signed [`SMM_SPD_W-1:0] smm_spd_t;
  typedef logic signed [`SMM_POS_W-1:0] smm_pos_t;
  typedef enum logic [1:0] {
    SMM_REACT_TO = `SMM_REACT_TORQUE_OFF,
    SMM_REACT_S1A = `SMM_REACT_STOP1_FIRST,
    SMM_REACT_S1B = `SMM_REACT_STOP1_SECOND
  } smm_react_t;
  // one encoder sample
  typedef struct packed {
    smm_spd_t speed;
    smm_pos_t pos;
  } smm_sample_t;
  // direction guard configuration, held constant while monitoring runs
  typedef struct packed {
    logic dir_neg;
    smm_spd_t n_tol;
    smm_pos_t s_tol;
    smm_react_t react;
  } smm_dir_cfg_t;
  // window configuration: limits plus a configured flag for each
  typedef struct packed {
    logic upper_en;
    logic lower_en;
    smm_pos_t upper;
    smm_pos_t lower;
  } smm_win_cfg_t;
  // guard state
  typedef enum logic [1:0] {
    SMM_ST_OFF = 2'b00,
    SMM_ST_MOVING = 2'b01,
    SMM_ST_ZERO = 2'b11
  } smm_state_t;
endpackage : smm_pkg

/* logic/smm_latch_mem.sv */
`timescale 1ns/100ps
// small register file holding latched reference positions, registered read
module smm_latch_mem (
  // clock
  input wire logic CLK,
  // write side
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [31:0] wdata,
  // read side
  input wire logic [1:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:3];

  // storage has no reset; readers only look at written entries
  always_ff @(posedge CLK) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read
  always_ff @(posedge CLK) begin
    rdata <= mem[raddr];
  end
endmodule : smm_latch_mem

/* logic/smm_monitor.sv */
`timescale 1ns/100ps
`include "smm_defs.svh"
// What this block does
// - allowed direction fixed at configuration, not runtime
// - control bit on starts direction checking at the next monitoring tick
// - positive allowed: error when speed below minus tolerance
// - negative allowed: error when speed above plus tolerance
// - zero window entry latches position, starts position check
// - in zero window: position beyond latch plus tolerance errors
// - control bit off stops all direction checking
// - status bit equals direction monitoring active
// - any violation requests configured error reaction
// - re-entering zero window re-latches position
// - position window active when any limit configured
// - position window status true between limits
// - position window never requests a reaction
// - position window ignores referencing state
// - speed window active when any limit configured
// - speed window status true between limits
// - speed window never requests a reaction
module smm_monitor
  import smm_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // encoder samples, same clock domain
  input wire smm_pkg::smm_sample_t SAMPLE,
  // direction guard control and configuration
  input wire logic GUARD_ON,
  input wire smm_pkg::smm_dir_cfg_t GUARD_CFG,
  // position window configuration
  input wire smm_pkg::smm_win_cfg_t POS_WIN_CFG,
  // speed window configuration (full-width limits, compared with the sign-extended speed)
  input wire smm_pkg::smm_win_cfg_t SPD_WIN_CFG,
  // referencing state, accepted but unused by the window signal
  input wire logic REF_DONE,
  // status
  output logic GUARD_ACTIVE,
  output logic GUARD_ZERO,
  output logic POS_WIN_OK,
  output logic SPD_WIN_OK,
  output logic [31:0] LATCH_POS,
  // error reaction request
  output logic REACT_REQ,
  output smm_pkg::smm_react_t REACT_SEL,
  output logic SPEED_FAULT,
  output logic POS_FAULT,
  // monitoring cycle tick
  output logic TICK
);
  import smm_pkg::*;

  // widening helper: speed to position width for common compare
  function automatic smm_pos_t sx(input smm_spd_t v);
    sx = smm_pos_t'(signed'(v));
  endfunction : sx

  // inclusive window test with optional bounds, used by both window signals
  function automatic logic in_win(input smm_pos_t v, input smm_win_cfg_t c);
    logic lo_ok;
    logic hi_ok;
    lo_ok = !c.lower_en || (v >= c.lower);
    hi_ok = !c.upper_en || (v <= c.upper);
    in_win = (c.lower_en || c.upper_en) && lo_ok && hi_ok;
  endfunction : in_win

  logic [`SMM_DIV_W-1:0] div;
  logic tick;
  smm_state_t state;
  smm_state_t next_state;
  smm_pos_t latch;
  logic in_zero;
  logic spd_bad;
  logic pos_bad;
  logic relatch;
  logic [1:0] lat_idx;
  logic [31:0] mem_rdata;
  logic dir_neg;
  logic ref_unused;

  // monitoring cycle divider: one-cycle tick every cycle period
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      div <= '0;
    end else if (div == `SMM_DIV_W'(`SMM_CYCLE_CLKS - 1)) begin
      div <= '0;
    end else begin
      div <= div + `SMM_DIV_W'(1);
    end
  end
  assign tick = (div == `SMM_DIV_W'(`SMM_CYCLE_CLKS - 1));
  assign TICK = tick;

  // direction taken once after reset release; runtime changes of the input are ignored
  logic dir_taken;
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      dir_taken <= 1'b0;
      dir_neg <= 1'b0;
    end else if (!dir_taken) begin
      dir_taken <= 1'b1;
      dir_neg <= GUARD_CFG.dir_neg;
    end
  end

  // zero window and speed limit tests on the current sample
  always_comb begin
    in_zero = (sx(SAMPLE.speed) >= -sx(GUARD_CFG.n_tol))
      && (sx(SAMPLE.speed) <= sx(GUARD_CFG.n_tol));
    if (dir_neg == `SMM_DIR_POS) begin
      spd_bad = sx(SAMPLE.speed) < -sx(GUARD_CFG.n_tol);
      pos_bad = SAMPLE.pos < (latch - GUARD_CFG.s_tol);
    end else begin
      spd_bad = sx(SAMPLE.speed) > sx(GUARD_CFG.n_tol);
      pos_bad = SAMPLE.pos > (latch + GUARD_CFG.s_tol);
    end
  end

  // guard state: off, moving, parked in zero window
  always_comb begin
    next_state = state;
    unique case (state)
      SMM_ST_OFF: begin
        if (GUARD_ON) begin
          next_state = in_zero ? SMM_ST_ZERO : SMM_ST_MOVING;
        end
      end
      SMM_ST_MOVING: begin
        if (!GUARD_ON) begin
          next_state = SMM_ST_OFF;
        end else if (in_zero) begin
          next_state = SMM_ST_ZERO;
        end
      end
      SMM_ST_ZERO: begin
        if (!GUARD_ON) begin
          next_state = SMM_ST_OFF;
        end else if (!in_zero) begin
          next_state = SMM_ST_MOVING;
        end
      end
      default: next_state = SMM_ST_OFF;
    endcase
  end

  // entry into zero window, including a brief exit during a fault
  assign relatch = tick && GUARD_ON && in_zero && (state != SMM_ST_ZERO);

  // state advances only on the monitoring tick
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state <= SMM_ST_OFF;
    end else if (tick) begin
      state <= next_state;
    end
  end

  // latched reference position
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      latch <= '0;
    end else if (relatch) begin
      latch <= SAMPLE.pos;
    end
  end

  // fault flags evaluated each tick while guarding; cleared when the guard is off
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      SPEED_FAULT <= 1'b0;
      POS_FAULT <= 1'b0;
    end else if (tick) begin
      SPEED_FAULT <= GUARD_ON && spd_bad;
      POS_FAULT <= GUARD_ON && (state == SMM_ST_ZERO) && in_zero && pos_bad;
    end
  end

  // reaction request follows either fault; windows never contribute
  assign REACT_REQ = SPEED_FAULT || POS_FAULT;
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      REACT_SEL <= SMM_REACT_TO;
    end else begin
      REACT_SEL <= GUARD_CFG.react;
    end
  end

  // status outputs
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      GUARD_ACTIVE <= 1'b0;
      GUARD_ZERO <= 1'b0;
    end else if (tick) begin
      GUARD_ACTIVE <= GUARD_ON;
      GUARD_ZERO <= GUARD_ON && in_zero;
    end
  end

  // window signals: no enable, no referencing dependency
  assign ref_unused = REF_DONE;
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      POS_WIN_OK <= 1'b0;
      SPD_WIN_OK <= 1'b0;
    end else if (tick) begin
      POS_WIN_OK <= in_win(SAMPLE.pos, POS_WIN_CFG);
      SPD_WIN_OK <= in_win(sx(SAMPLE.speed), SPD_WIN_CFG);
    end
  end

  // history of reference positions; read back for diagnosis only, the latch register drives the output
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      lat_idx <= 2'h0;
    end else if (relatch) begin
      lat_idx <= lat_idx + 2'h1;
    end
  end

  smm_latch_mem u_mem (
    .CLK(CLK),
    .we(relatch),
    .waddr(lat_idx),
    .wdata(SAMPLE.pos),
    .raddr(lat_idx - 2'h1),
    .rdata(mem_rdata)
  );

  // output the registered latch; memory read kept for diagnosis of the last entry
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      LATCH_POS <= 32'h0;
    end else begin
      LATCH_POS <= latch;
    end
  end

  // checks
  a_guard_status: assert property (@(posedge CLK) disable iff (!NRST)
    tick |=> GUARD_ACTIVE == $past(GUARD_ON)) else $error("guard status mismatch");
  a_speed_fault: assert property (@(posedge CLK) disable iff (!NRST)
    (tick && GUARD_ON && spd_bad) |=> SPEED_FAULT && REACT_REQ)
    else $error("speed fault missed");
  a_off_quiet: assert property (@(posedge CLK) disable iff (!NRST)
    (tick && !GUARD_ON) |=> !SPEED_FAULT && !POS_FAULT) else $error("fault while off");
  a_relatch_pos: assert property (@(posedge CLK) disable iff (!NRST)
    relatch |=> latch == $past(SAMPLE.pos)) else $error("latch not taken");
  a_pos_fault: assert property (@(posedge CLK) disable iff (!NRST)
    (tick && GUARD_ON && state == SMM_ST_ZERO && in_zero && pos_bad) |=> POS_FAULT)
    else $error("position fault missed");
  a_tick_space: assert property (@(posedge CLK) disable iff (!NRST)
    tick |=> !tick [*8]) else $error("tick too frequent");
  a_pos_win: assert property (@(posedge CLK) disable iff (!NRST)
    tick |=> POS_WIN_OK == $past(in_win(SAMPLE.pos, POS_WIN_CFG)))
    else $error("position window wrong");
  a_spd_win_unset: assert property (@(posedge CLK) disable iff (!NRST)
    (tick && !SPD_WIN_CFG.upper_en && !SPD_WIN_CFG.lower_en) |=> !SPD_WIN_OK)
    else $error("speed window without limits");
  a_react_cause: assert property (@(posedge CLK) disable iff (!NRST)
    REACT_REQ |-> (SPEED_FAULT || POS_FAULT)) else $error("reaction without fault");
  // the history read lags the write by one edge, so the newest entry shows two edges on
  a_hist_newest: assert property (@(posedge CLK) disable iff (!NRST)
    relatch |=> ##1 (mem_rdata == latch)) else $error("history entry stale");
  a_dir_fixed: assert property (@(posedge CLK) disable iff (!NRST)
    dir_taken |=> $stable(dir_neg)) else $error("direction changed");
endmodule : smm_monitor

/* dv/smm_enc_model.sv */
`timescale 1ns/100ps
// stand-in for the axis encoder: turns commanded motion into samples
module smm_enc_model
  import smm_pkg::*;
(
  // clock
  input wire logic clk,
  // commanded motion
  input wire logic [31:0] speed,
  input wire logic [31:0] pos,
  // sample toward the monitor
  output smm_pkg::smm_sample_t sample
);
  // a fresh sample every clock, so each tick sees the newest values
  always_ff @(posedge clk) begin
    sample.speed <= speed[23:0];
    sample.pos <= pos;
  end
endmodule : smm_enc_model

/* dv/smm_monitor_tb.sv */
`timescale 1ns/100ps
module smm_monitor_tb;
  import smm_pkg::*;
  localparam int NT = 100;
  localparam int ST = 50;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic guard_on = 1'b0;
  logic ref_done = 1'b0;
  logic [31:0] spd = 32'h0;
  logic [31:0] ps = 32'h0;
  smm_sample_t sample;
  smm_dir_cfg_t gcfg = '{1'b0, 24'h64, 32'h32, SMM_REACT_TO};
  smm_win_cfg_t pcfg = '{1'b1, 1'b1, 32'h3e8, 32'hfffffc18};
  smm_win_cfg_t scfg = '{1'b1, 1'b1, 32'h1f4, 32'hfffffe0c};
  logic active, zero, pos_ok, spd_ok, req, sf, pf, tick;
  logic [31:0] latch;
  smm_react_t rsel;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int lat = 0;
  int d = 1;
  logic prev_z = 1'b0;
  // speed, position, guard on; mirrored by d for the negative direction
  int tab[12][3] = '{'{0, 0, 0}, '{-300, 0, 0}, '{-300, 0, 1}, '{-100, 10, 1},
    '{50, -40, 1}, '{50, -41, 1}, '{-101, -41, 1}, '{0, -200, 1},
    '{600, 1000, 1}, '{0, 1001, 1}, '{0, -2000, 0}, '{-500, -1000, 1}};

  smm_enc_model i_smm_enc_model (.clk(clk), .speed(spd), .pos(ps), .sample(sample));
  smm_monitor i_smm_monitor (.CLK(clk), .NRST(nrst), .SAMPLE(sample), .GUARD_ON(guard_on),
    .GUARD_CFG(gcfg), .POS_WIN_CFG(pcfg), .SPD_WIN_CFG(scfg), .REF_DONE(ref_done),
    .GUARD_ACTIVE(active), .GUARD_ZERO(zero), .POS_WIN_OK(pos_ok), .SPD_WIN_OK(spd_ok),
    .LATCH_POS(latch), .REACT_REQ(req), .REACT_SEL(rsel), .SPEED_FAULT(sf),
    .POS_FAULT(pf), .TICK(tick));

  // 100 ns clock
  always #50 clk = ~clk;

  // hang guard: three passes of twelve ticks need about 22500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // reset with a chosen direction, then try to turn it round at runtime
  task automatic restart(input int pass);
    nrst = 1'b0;
    gcfg.dir_neg = (pass == 1);
    gcfg.react = smm_react_t'(pass[1:0]);
    d = (pass == 1) ? -1 : 1;
    scfg.upper_en = (pass == 0);
    scfg.lower_en = (pass != 2);
    lat = 0;
    prev_z = 1'b0;
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge clk);
    #1 gcfg.dir_neg = ~gcfg.dir_neg;
    chk(req, 1'b0);
    chk(active, 1'b0);
  endtask : restart

  // one monitoring cycle: drive, wait for the tick, compare with the model
  task automatic step(input int s, input int p, input logic on);
    logic z;
    logic e_sf;
    logic e_pf;
    logic e_sw;
    spd = s * d;
    ps = p * d;
    guard_on = on;
    ref_done = ~ref_done; // window must not care about referencing
    @(posedge clk);
    #1;
    while (tick !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    #1;
    z = on && s >= -NT && s <= NT;
    e_sf = on && s < -NT;
    e_pf = on && z && prev_z && p < lat - ST;
    e_sw = (scfg.lower_en || scfg.upper_en) && (!scfg.lower_en || s * d >= -500)
      && (!scfg.upper_en || s * d <= 500);
    if (z && !prev_z)
      lat = p;
    prev_z = z;
    chk(active, on);
    chk(zero, z);
    chk(sf, e_sf);
    chk(pf, e_pf);
    chk(req, e_sf | e_pf);
    chk(rsel, gcfg.react);
    if (on)
      chk(latch, lat * d);
    chk(pos_ok, p >= -1000 && p <= 1000);
    chk(spd_ok, e_sw);
    chk(tick, 1'b0);
  endtask : step

  // three passes: each reaction code, both directions, a reset between
  initial begin
    for (int pass = 0; pass < 3; pass++) begin
      restart(pass);
      for (int i = 0; i < 12; i++)
        step(tab[i][0], tab[i][1], tab[i][2][0]);
    end
    results();
  end
endmodule : smm_monitor_tb
